// ---- rtl/spfbc_top.sv ----
// Top of the serial frame and rate configuration block: registers and crossings
//
// Chosen here: strobed register access.
module spfbc_top (
    input  logic       clock,
    input  logic       rstn,
    input  logic [4:0] addr,
    input  logic [7:0] wdata,
    input  logic       wr,
    input  logic       rd,
    output logic [7:0] rdata,
    input  logic       cpu_halted,
    input  logic       link_clk,
    input  logic       rx_pin,
    input  logic       event_in,
    input  logic       tx_bit,
    output logic       ir_tx,
    output logic       sample_tick,
    output logic       multi_node_addressing_enable,
    output logic [1:0] communication_mode_select,
    output logic       host_spi_operation,
    output logic       infrared_operation,
    output logic [1:0] receive_mode_select,
    output logic       constrained_autorate_mode,
    output logic       parity_enable,
    output logic       parity_odd,
    output logic       stop_bit_count,
    output logic [3:0] character_width,
    output logic       nine_bit_low_first,
    output logic       nine_bit_high_first,
    output logic       bit_order_select,
    output logic       clock_phase_select,
    output logic [1:0] autorate_window,
    output logic       run_while_halted,
    output logic       infrared_event_input_enable,
    output logic [7:0] tx_pulse_length
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                  multi_node;
        logic [1:0]            rx_mode;
        logic [1:0]            mode;
        logic [1:0]            parity;
        logic                  stop2;
        logic [2:0]            width;
        logic                  order;
        logic                  phase;
        logic [15:0]           divisor;
        logic [1:0]            window;
        logic                  run;
        logic                  ev_dis;
        logic [7:0]            pulse;
        logic [7:0]            rdata;
        spfbc_pkg::spfbc_cfg_t shadow;
        logic                  launch_tgl;
        logic [1:0]            ack_sync;
        logic [2:0]            ok_sync;
        logic [2:0]            err_sync;
        logic                  st_ok;
        logic                  st_err;
        logic                  par_en;
        logic                  par_odd;
        logic [3:0]            bits;
        logic                  low_first;
        logic                  high_first;
    } spfbc_top_state_t;

    spfbc_top_state_t      s;
    spfbc_top_state_t      n;
    spfbc_pkg::spfbc_cfg_t cur;
    logic                  clr_ok;
    logic                  clr_err;
    logic                  ok_evt;
    logic                  err_evt;
    logic                  busy;

    spfbc_if bus ();

    spfbc_link u_link (
        .link_clk    (link_clk),
        .rstn        (rstn),
        .bus         (bus),
        .rx_pin      (rx_pin),
        .event_in    (event_in),
        .tx_bit      (tx_bit),
        .ir_tx       (ir_tx),
        .sample_tick (sample_tick)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        n          = s;
        n.rdata    = 8'h00;
        clr_ok     = 1'b0;
        clr_err    = 1'b0;
        n.ack_sync = {s.ack_sync[0], bus.ack_tgl};
        n.ok_sync  = {s.ok_sync[1:0], bus.ok_tgl};
        n.err_sync = {s.err_sync[1:0], bus.err_tgl};
        ok_evt     = s.ok_sync[2] ^ s.ok_sync[1];
        err_evt    = s.err_sync[2] ^ s.err_sync[1];
        busy       = s.launch_tgl != s.ack_sync[1];

        // Register writes
        if (wr) begin
            case (addr)
                spfbc_pkg::OFS_RECV_CTRL: begin
                    n.multi_node = wdata[spfbc_pkg::MULTI_NODE_ADDRESSING_ENABLE_BIT];
                    n.rx_mode    = wdata[spfbc_pkg::RECEIVE_MODE_SELECT_LSB +: 2];
                end
                spfbc_pkg::OFS_FRAME: begin
                    n.mode = wdata[spfbc_pkg::MODE_LSB +: 2];
                    // The byte's own mode picks which field set it carries
                    if (wdata[spfbc_pkg::MODE_LSB +: 2] == spfbc_pkg::MODE_HOST_SPI) begin
                        n.order = wdata[spfbc_pkg::ORDER_BIT];
                        n.phase = wdata[spfbc_pkg::PHASE_BIT];
                    end else begin
                        n.parity = wdata[spfbc_pkg::PAR_LSB +: 2];
                        n.stop2  = wdata[spfbc_pkg::STOP_BIT];
                        n.width  = wdata[spfbc_pkg::WIDTH_LSB +: 3];
                    end
                end
                spfbc_pkg::OFS_DIV_LO: begin
                    n.divisor[7:0] = wdata;
                end
                spfbc_pkg::OFS_DIV_HI: begin
                    n.divisor[15:8] = wdata;
                end
                spfbc_pkg::OFS_WINDOW: begin
                    n.window = wdata[spfbc_pkg::WINDOW_LSB +: 2];
                end
                spfbc_pkg::OFS_DEBUG: begin
                    n.run = wdata[spfbc_pkg::RUN_BIT];
                end
                spfbc_pkg::OFS_EVENT: begin
                    n.ev_dis = wdata[spfbc_pkg::EVDIS_BIT];
                end
                spfbc_pkg::OFS_PULSE: begin
                    n.pulse = wdata;
                end
                spfbc_pkg::OFS_STATUS: begin
                    clr_ok  = wdata[spfbc_pkg::ST_OK_BIT];
                    clr_err = wdata[spfbc_pkg::ST_ERR_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data valid in the following cycle only
        if (rd) begin
            case (addr)
                spfbc_pkg::OFS_RECV_CTRL: begin
                    n.rdata[spfbc_pkg::MULTI_NODE_ADDRESSING_ENABLE_BIT]        = s.multi_node;
                    n.rdata[spfbc_pkg::RECEIVE_MODE_SELECT_LSB +: 2] = s.rx_mode;
                end
                spfbc_pkg::OFS_FRAME: begin
                    n.rdata[spfbc_pkg::MODE_LSB +: 2] = s.mode;
                    if (s.mode == spfbc_pkg::MODE_HOST_SPI) begin
                        n.rdata[spfbc_pkg::ORDER_BIT] = s.order;
                        n.rdata[spfbc_pkg::PHASE_BIT] = s.phase;
                    end else begin
                        n.rdata[spfbc_pkg::PAR_LSB +: 2]   = s.parity;
                        n.rdata[spfbc_pkg::STOP_BIT]       = s.stop2;
                        n.rdata[spfbc_pkg::WIDTH_LSB +: 3] = s.width;
                    end
                end
                spfbc_pkg::OFS_DIV_LO: begin
                    n.rdata = s.divisor[7:0];
                end
                spfbc_pkg::OFS_DIV_HI: begin
                    n.rdata = s.divisor[15:8];
                end
                spfbc_pkg::OFS_WINDOW: begin
                    n.rdata[spfbc_pkg::WINDOW_LSB +: 2] = s.window;
                end
                spfbc_pkg::OFS_DEBUG: begin
                    n.rdata[spfbc_pkg::RUN_BIT] = s.run;
                end
                spfbc_pkg::OFS_EVENT: begin
                    n.rdata[spfbc_pkg::EVDIS_BIT] = s.ev_dis;
                end
                spfbc_pkg::OFS_PULSE: begin
                    n.rdata = s.pulse;
                end
                spfbc_pkg::OFS_STATUS: begin
                    n.rdata[spfbc_pkg::ST_OK_BIT]   = s.st_ok;
                    n.rdata[spfbc_pkg::ST_ERR_BIT]  = s.st_err;
                    n.rdata[spfbc_pkg::ST_BUSY_BIT] = busy;
                end
                default: begin
                    n.rdata = 8'h00;
                end
            endcase
        end

        // Sticky window results; a new event beats a clear in the same cycle
        n.st_ok  = (s.st_ok & ~clr_ok) | ok_evt;
        n.st_err = (s.st_err & ~clr_err) | err_evt;

        // Decoded frame format for the data path
        n.par_en     = (n.parity == spfbc_pkg::PAR_EVEN)
                    || (n.parity == spfbc_pkg::PAR_ODD);
        n.par_odd    = n.parity == spfbc_pkg::PAR_ODD;
        n.bits       = spfbc_pkg::data_bits(n.width);
        n.low_first  = n.width == spfbc_pkg::WIDTH_9_LOW;
        n.high_first = n.width == spfbc_pkg::WIDTH_9_HIGH;

        // Link-side copy: one word in flight, newest settings follow next
        cur.divisor = s.divisor;
        cur.mode    = s.mode;
        cur.rx_mode = s.rx_mode;
        cur.window  = s.window;
        cur.run     = s.run;
        cur.ev_dis  = s.ev_dis;
        cur.pulse   = s.pulse;
        if (!busy && cur != s.shadow) begin
            n.shadow     = cur;
            n.launch_tgl = ~s.launch_tgl;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s                <= '0;
            s.mode           <= spfbc_pkg::MODE_ASYNC;
            s.parity         <= spfbc_pkg::PAR_RST;
            s.width          <= spfbc_pkg::WIDTH_RST;
            s.divisor        <= spfbc_pkg::DIV_RST;
            s.pulse          <= spfbc_pkg::PULSE_RST;
            s.shadow.mode    <= spfbc_pkg::MODE_ASYNC;
            s.shadow.divisor <= spfbc_pkg::DIV_RST;
            s.shadow.pulse   <= spfbc_pkg::PULSE_RST;
            s.bits           <= 4'h8;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign bus.cfg                      = s.shadow;
    assign bus.launch_tgl               = s.launch_tgl;
    // Halt comes from logic on this clock; the link side synchronises it
    assign bus.halt                     = cpu_halted;
    assign rdata                        = s.rdata;
    assign multi_node_addressing_enable = s.multi_node;
    assign communication_mode_select    = s.mode;
    assign host_spi_operation           = s.mode == spfbc_pkg::MODE_HOST_SPI;
    assign infrared_operation           = s.mode == spfbc_pkg::MODE_INFRARED;
    assign receive_mode_select          = s.rx_mode;
    assign constrained_autorate_mode    = s.rx_mode == spfbc_pkg::RECEIVE_MODE_SELECT_WINDOW;
    assign parity_enable                = s.par_en;
    assign parity_odd                   = s.par_odd;
    // Receiver must not look at this one
    assign stop_bit_count               = s.stop2;
    assign character_width              = s.bits;
    assign nine_bit_low_first           = s.low_first;
    assign nine_bit_high_first          = s.high_first;
    assign bit_order_select             = s.order;
    assign clock_phase_select           = s.phase;
    assign autorate_window              = s.window;
    assign run_while_halted             = s.run;
    assign infrared_event_input_enable  = ~s.ev_dis;
    assign tx_pulse_length              = s.pulse;
endmodule // spfbc_top

// ---- rtl/spfbc_pkg.sv ----
// Constants, types and helpers shared by the serial frame and rate configuration block
// ----------------------------------------------------------------------------
// Functional notes
// - One bit turns multi-node addressing on when one, off when zero.
// - Mode field bits 7:6 selects asynchronous, synchronous, infrared or host SPI.
// - In host SPI mode frame control shows only mode, bit order and clock phase.
// - Parity field: 0 off, 1 reserved, 2 even, 3 odd.
// - Stop setting gives one or two transmit stop bits; receiver ignores it.
// - Width codes 0-3 give 5-8 bits; 6 and 7 give nine bits.
// - Nine-bit byte access order follows low-first or high-first code.
// - Host SPI bit order bit: zero sends MSB first, one LSB first.
// - Host SPI phase bit: zero samples leading edge, one trailing edge.
// - Rate divisor is 16 bits: low byte at 0x08, high byte above.
// - A divisor change reloads the prescaler once the new word reaches the link side.
// - Receiver takes sixteen samples per bit; a bit pair spans thirty-two.
// - Window field accepts pair span 32 within 6, 5, 7 or 8 samples.
// - Run bit zero stops the link logic and ignores events while halted.
// - Event input select: value zero enables event channel, one disables it.
// - Receive mode code 3 enables the constrained auto-rate window check.
// - Pulse length: 0 gives 3/16 bit, 1-254 clocks, 255 passes through.
// ----------------------------------------------------------------------------
package spfbc_pkg;
    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  OFS_RECV_CTRL   = 5'h06;
    localparam logic [4:0]  OFS_FRAME       = 5'h07;
    localparam logic [4:0]  OFS_DIV_LO      = 5'h08;
    localparam logic [4:0]  OFS_DIV_HI      = 5'h09;
    localparam logic [4:0]  OFS_WINDOW      = 5'h0a;
    localparam logic [4:0]  OFS_DEBUG       = 5'h0b;
    localparam logic [4:0]  OFS_EVENT       = 5'h0c;
    localparam logic [4:0]  OFS_PULSE       = 5'h0d;
    localparam logic [4:0]  OFS_STATUS      = 5'h10;
    localparam int          MULTI_NODE_ADDRESSING_ENABLE_BIT        = 0;
    localparam int          RECEIVE_MODE_SELECT_LSB      = 1;
    localparam int          MODE_LSB        = 6;
    localparam int          PAR_LSB         = 4;
    localparam int          STOP_BIT        = 3;
    localparam int          WIDTH_LSB       = 0;
    localparam int          ORDER_BIT       = 2;
    localparam int          PHASE_BIT       = 1;
    localparam int          WINDOW_LSB      = 6;
    localparam int          RUN_BIT         = 0;
    localparam int          EVDIS_BIT       = 0;
    localparam int          ST_OK_BIT       = 0;
    localparam int          ST_ERR_BIT      = 1;
    localparam int          ST_BUSY_BIT     = 2;
    localparam logic [1:0]  PAR_RST         = 2'h0;
    localparam logic [2:0]  WIDTH_RST       = 3'h3;
    localparam logic [15:0] DIV_RST         = 16'h0000;
    localparam logic [7:0]  PULSE_RST       = 8'h00;
    localparam logic [1:0]  PAR_EVEN        = 2'h2;
    localparam logic [1:0]  PAR_ODD         = 2'h3;
    localparam logic [2:0]  WIDTH_9_LOW     = 3'h6;
    localparam logic [2:0]  WIDTH_9_HIGH    = 3'h7;
    localparam logic [1:0]  RECEIVE_MODE_SELECT_WINDOW   = 2'h3;
    localparam logic [5:0]  PAIR_SPAN       = 6'h20;
    localparam logic [5:0]  SPAN_MAX        = 6'h3f;
    localparam logic [7:0]  PULSE_SHORT     = 8'h00;
    localparam logic [7:0]  PULSE_PASS      = 8'hff;
    localparam logic [7:0]  SHORT_TICKS     = 8'h03;
    localparam logic [3:0]  BIT_START_PHASE = 4'h0;

    typedef enum logic [1:0] {
        MODE_ASYNC    = 2'h0,
        MODE_SYNC     = 2'h1,
        MODE_INFRARED = 2'h2,
        MODE_HOST_SPI = 2'h3
    } spfbc_mode_t;

    typedef enum logic [1:0] {
        AB_IDLE  = 2'b01,
        AB_ARMED = 2'b10
    } spfbc_ab_t;

    typedef struct packed {
        logic [15:0] divisor;
        logic [1:0]  mode;
        logic [1:0]  rx_mode;
        logic [1:0]  window;
        logic        run;
        logic        ev_dis;
        logic [7:0]  pulse;
    } spfbc_cfg_t;

    function automatic logic [3:0] data_bits(input logic [2:0] code);
        case (code)
            3'h0:         data_bits = 4'h5;
            3'h1:         data_bits = 4'h6;
            3'h2:         data_bits = 4'h7;
            WIDTH_9_LOW:  data_bits = 4'h9;
            WIDTH_9_HIGH: data_bits = 4'h9;
            default:      data_bits = 4'h8;
        endcase
    endfunction

    function automatic logic [5:0] tolerance(input logic [1:0] code);
        case (code)
            2'h0:    tolerance = 6'h06;
            2'h1:    tolerance = 6'h05;
            2'h2:    tolerance = 6'h07;
            default: tolerance = 6'h08;
        endcase
    endfunction
endpackage

// ---- rtl/spfbc_if.sv ----
// Carrier between register side and link side of the configuration block
interface spfbc_if;
    spfbc_pkg::spfbc_cfg_t cfg;
    logic                  launch_tgl;
    logic                  ack_tgl;
    logic                  halt;
    logic                  ok_tgl;
    logic                  err_tgl;
    modport core (output cfg, output launch_tgl, output halt,
                  input ack_tgl, input ok_tgl, input err_tgl);
    modport link (input cfg, input launch_tgl, input halt,
                  output ack_tgl, output ok_tgl, output err_tgl);
endinterface

// ---- rtl/spfbc_link.sv ----
// Link-clock logic: rate prescaler, auto-rate window check, infrared pulse shaping
module spfbc_link (
    input  logic   link_clk,
    input  logic   rstn,
    spfbc_if.link  bus,
    input  logic   rx_pin,
    input  logic   event_in,
    input  logic   tx_bit,
    output logic   ir_tx,
    output logic   sample_tick
);
    typedef struct packed {
        spfbc_pkg::spfbc_cfg_t cfg;
        logic [1:0]            cfg_sync;
        logic                  ack_tgl;
        logic [1:0]            halt_sync;
        logic [1:0]            rx_sync;
        logic [1:0]            ev_sync;
        logic                  rx_prev;
        logic [15:0]           presc;
        logic                  tick;
        logic [3:0]            phase_cnt;
        spfbc_pkg::spfbc_ab_t  ab_state;
        logic [5:0]            span;
        logic                  ok_tgl;
        logic                  err_tgl;
        logic [7:0]            pulse_cnt;
        logic                  ir_out;
    } spfbc_link_state_t;

    spfbc_link_state_t s;
    spfbc_link_state_t n;
    logic              frozen;
    logic              rx_src;
    logic              fall;
    logic              in_win;
    logic              short_mode;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        n           = s;
        n.cfg_sync  = {s.cfg_sync[0], bus.launch_tgl};
        n.halt_sync = {s.halt_sync[0], bus.halt};
        n.rx_sync   = {s.rx_sync[0], rx_pin};
        n.ev_sync   = {s.ev_sync[0], event_in};
        n.tick      = 1'b0;
        frozen      = s.halt_sync[1] & ~s.cfg.run;
        rx_src      = (s.cfg.mode == spfbc_pkg::MODE_INFRARED && !s.cfg.ev_dis)
                      ? s.ev_sync[1] : s.rx_sync[1];
        fall        = s.rx_prev & ~rx_src & ~frozen;
        in_win      = (s.span >= spfbc_pkg::PAIR_SPAN - spfbc_pkg::tolerance(s.cfg.window))
                   && (s.span <= spfbc_pkg::PAIR_SPAN + spfbc_pkg::tolerance(s.cfg.window));
        short_mode  = s.cfg.pulse == spfbc_pkg::PULSE_SHORT;
        n.rx_prev   = rx_src;
        if (!frozen) begin
            if (s.presc == 16'h0000) begin
                n.tick      = 1'b1;
                n.presc     = s.cfg.divisor;
                n.phase_cnt = s.phase_cnt + 4'h1;
            end else begin
                n.presc = s.presc - 16'h0001;
            end
        end
        // Word is stable: the core side holds it until this toggle returns
        if (s.cfg_sync[1] != s.ack_tgl) begin
            n.cfg     = bus.cfg;
            n.ack_tgl = s.cfg_sync[1];
            n.presc   = bus.cfg.divisor;
        end
        if (s.cfg.rx_mode != spfbc_pkg::RECEIVE_MODE_SELECT_WINDOW) begin
            n.ab_state = spfbc_pkg::AB_IDLE;
        end else begin
            case (s.ab_state)
                spfbc_pkg::AB_IDLE: begin
                    if (fall) begin
                        n.ab_state = spfbc_pkg::AB_ARMED;
                        n.span     = {5'h00, n.tick};
                    end
                end
                spfbc_pkg::AB_ARMED: begin
                    if (fall) begin
                        // Tick at the edge opens the next span
                        n.span = {5'h00, n.tick};
                        if (in_win) begin
                            n.ok_tgl = ~s.ok_tgl;
                        end else begin
                            n.err_tgl = ~s.err_tgl;
                        end
                    end else if (n.tick && s.span != spfbc_pkg::SPAN_MAX) begin
                        n.span = s.span + 6'h01;
                    end
                end
                default: n.ab_state = spfbc_pkg::AB_IDLE;
            endcase
        end
        if (s.cfg.mode != spfbc_pkg::MODE_INFRARED || s.cfg.pulse == spfbc_pkg::PULSE_PASS) begin
            n.ir_out    = tx_bit;
            n.pulse_cnt = 8'h00;
        end else if (!frozen) begin
            if (n.tick && s.phase_cnt == spfbc_pkg::BIT_START_PHASE && !tx_bit) begin
                n.pulse_cnt = short_mode ? spfbc_pkg::SHORT_TICKS : s.cfg.pulse;
            end else if (s.pulse_cnt != 8'h00 && (n.tick || !short_mode)) begin
                n.pulse_cnt = s.pulse_cnt - 8'h01;
            end
            n.ir_out = n.pulse_cnt != 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            s          <= '0;
            s.cfg.divisor <= spfbc_pkg::DIV_RST;
            s.cfg.pulse   <= spfbc_pkg::PULSE_RST;
            s.presc    <= spfbc_pkg::DIV_RST;
            s.ab_state <= spfbc_pkg::AB_IDLE;
            s.rx_sync  <= 2'b11;
            s.ev_sync  <= 2'b11;
            s.rx_prev  <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign bus.ack_tgl = s.ack_tgl;
    assign bus.ok_tgl  = s.ok_tgl;
    assign bus.err_tgl = s.err_tgl;
    assign ir_tx       = s.ir_out;
    assign sample_tick = s.tick;
endmodule // spfbc_link

// ---- tb/spfbc_sva.sv ----
// Checker for the register-side outputs of the configuration block
module spfbc_sva (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [1:0] communication_mode_select,
    input wire logic       host_spi_operation,
    input wire logic       multi_node_addressing_enable,
    input wire logic       parity_enable,
    input wire logic       parity_odd,
    input wire logic [3:0] character_width,
    input wire logic       run_while_halted
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence frame_wr;
        wr && addr == 5'h07 && wdata[7:6] != 2'h3;
    endsequence
    AST_MODE: assert property (host_spi_operation == (communication_mode_select == 2'h3))
        else $error("host SPI flag does not follow mode");
    AST_MULTI_NODE_ADDRESSING_ENABLE: assert property (wr && addr == 5'h06 |=>
        multi_node_addressing_enable == $past(wdata[0]))
        else $error("multi-node bit not stored");
    AST_W5: assert property (frame_wr ##0 (wdata[2:0] == 3'h0) |=> character_width == 4'h5)
        else $error("width code 0 not five bits");
    AST_PAR: assert property (frame_wr |=> parity_enable == $past(wdata[5]) &&
        parity_odd == $past(wdata[5] & wdata[4]))
        else $error("parity decode wrong");
    AST_SPI: assert property (wr && addr == 5'h07 && wdata[7:6] == 2'h3 |=>
        $stable(character_width))
        else $error("host SPI write disturbed width");
    AST_RDF: assert property (rd && addr == 5'h07 |=>
        rdata[7:6] == communication_mode_select)
        else $error("mode field read wrong");
    AST_RUN: assert property (rd && addr == 5'h0b |=> rdata == {7'h00, run_while_halted})
        else $error("run bit read wrong");
    AST_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule // spfbc_sva
bind spfbc_top spfbc_sva u_sva (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .communication_mode_select, .host_spi_operation, .multi_node_addressing_enable,
    .parity_enable, .parity_odd, .character_width, .run_while_halted);

// ---- tb/spfbc_remote.sv ----
// Remote serial device driving falling edges on the receive line
module spfbc_remote (
    input wire logic link_clk,
    input wire logic go,
    input var int    gap,
    output logic     rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_pin = 1'b1; // Pulled-up line idles high
        forever begin
            @(posedge link_clk);
            if (go) begin
                rx_pin <= 1'b0;
                repeat (2) @(posedge link_clk);
                rx_pin <= 1'b1;
                repeat (gap - 3) @(posedge link_clk);
            end
        end
    end
endmodule // spfbc_remote

// ---- tb/spfbc_tb.sv ----
// Testbench for the configuration block
module spfbc_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, link_clk = 0, rstn = 0, wr = 0, rd = 0, go = 0, halt = 0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata;
    logic [3:0] character_width;
    logic stop_bit_count, nine_bit_high_first;
    logic rx_pin, host_spi_operation, bit_order_select, clock_phase_select, parity_odd;
    int gap = 32, err_total = 0, checks_done = 0;
    always #12.5 clock = ~clock;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    spfbc_remote peer (.link_clk, .go, .gap, .rx_pin);
    spfbc_top dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cpu_halted(halt), .link_clk,
        .rx_pin, .event_in(1'b1), .tx_bit(1'b1), .ir_tx(), .sample_tick(),
        .multi_node_addressing_enable(), .communication_mode_select(), .host_spi_operation,
        .infrared_operation(), .receive_mode_select(), .constrained_autorate_mode(),
        .parity_enable(), .parity_odd, .stop_bit_count, .character_width, .run_while_halted(),
        .nine_bit_low_first(), .nine_bit_high_first, .bit_order_select, .clock_phase_select,
        .autorate_window(), .infrared_event_input_enable(), .tx_pulse_length());
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    // Span run: window register byte w, edge spacing g, expected status m
    task run_span(input logic [7:0] w, input int g, input logic [7:0] m);
        wr_reg(5'h06, 8'h00);
        wr_reg(5'h0a, w);
        wr_reg(5'h06, 8'h06);
        wr_reg(5'h10, 8'h03);
        gap = g;
        repeat (20) @(posedge clock);
        go <= 1'b1;
        repeat (300) @(posedge clock);
        go <= 1'b0;
        repeat (10) @(posedge clock);
        rd_chk(5'h10, 8'hff, m);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(5'h07, 8'hff, 8'h03);
        rd_chk(5'h1f, 8'hff, 8'h00);
        wr_reg(5'h07, 8'hc6);
        rd_chk(5'h07, 8'hff, 8'hc6);
        chk({5'h00, host_spi_operation, bit_order_select, clock_phase_select}, 8'h07);
        wr_reg(5'h07, 8'h3f);
        rd_chk(5'h07, 8'hff, 8'h3f);
        chk({1'b0, stop_bit_count, parity_odd, nine_bit_high_first, character_width},
            8'h79);
        for (int i = 0; i < 4; i++) begin
            wr_reg(5'h07, 8'(i));
            chk({4'h0, character_width}, 8'(5 + i));
        end
        wr_reg(5'h08, 8'h34);
        wr_reg(5'h09, 8'h12);
        rd_chk(5'h08, 8'hff, 8'h34);
        rd_chk(5'h09, 8'hff, 8'h12);
        wr_reg(5'h08, 8'h00);
        wr_reg(5'h09, 8'h00);
        run_span(8'h00, 38, 8'h01);
        run_span(8'h00, 39, 8'h02);
        run_span(8'hc0, 39, 8'h01);
        run_span(8'h40, 39, 8'h02);
        @(posedge clock) halt <= 1'b1;
        run_span(8'h00, 38, 8'h00);
        wr_reg(5'h0b, 8'h01);
        rd_chk(5'h0b, 8'hff, 8'h01);
        run_span(8'h00, 32, 8'h01);
        end_of_test;
    end
    initial begin
        #200000;
        err_total++;
        end_of_test;
    end
endmodule // spfbc_tb
